// ---- inc/aopt_pkg.sv ----
package aopt_pkg;

  // ------------------------------------------------------------
  // Register map (byte offsets, one 32-bit word each)
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_CMD    = 5'h04;
  localparam logic [4:0] OFS_DIV    = 5'h08;
  localparam logic [4:0] OFS_DATA0  = 5'h0c;
  localparam logic [4:0] OFS_DATA1  = 5'h10;
  localparam logic [4:0] OFS_THRESH = 5'h14;
  localparam logic [4:0] OFS_FIFO   = 5'h18;
  localparam logic [4:0] OFS_STAT   = 5'h1c;

  // ------------------------------------------------------------
  // Field positions and codes
  // ------------------------------------------------------------
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT  = 1;
  localparam int CMD_FRST_BIT  = 2;
  localparam int STAT_ARM_BIT  = 0;
  localparam int STAT_TRG_BIT  = 1;
  localparam int STAT_CNT_LSB  = 16;
  localparam logic [1:0] TRIG_SW  = 2'h0;
  localparam logic [1:0] TRIG_EXT = 2'h1;
  localparam logic [1:0] TRIG_ANA = 2'h2;

  // Control word, top bit first
  typedef struct packed {
    logic [1:0] filt_en;     // Smoothing filter per channel
    logic       fifo_mode;   // Samples come from the output FIFO
    logic       first_one;   // List entry 0 is channel one
    logic       two_entries; // List holds two entries
    logic       ana_ai;      // Threshold source: input channel
    logic       trig_rise;   // Trigger polarity: rising
    logic [1:0] trig_src;    // Software, external, analog
    logic       clk_ext;     // Pacing from external clock pin
  } aopt_ctrl_t;

  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int          CODE_W       = 16;
  localparam int          DIV_W        = 24;
  localparam int          FIFO_AW      = 12;
  localparam int          FIFO_DEPTH   = 4096;
  localparam aopt_ctrl_t  CTRL_RST     = '0;
  localparam logic [23:0] DIV_RST      = 24'h0003e8;
  localparam logic [7:0]  THRESH_RST   = 8'h80;
  localparam logic [15:0] MID_CODE_16  = 16'h8000;
  localparam logic [15:0] MID_CODE_12  = 16'h0800;
  localparam logic [15:0] MASK_12      = 16'h0fff;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ        = 100_000_000;
  localparam longint TB_HZ         = 20_000_000;
  localparam longint MIN_RATE_MHZ  = 1200;   // 1.2 Hz in milli-hertz
  localparam longint MAX_RATE_S_HZ = 500_000;
  localparam longint MAX_RATE_L_HZ = 200_000;
  localparam logic [2:0]  TB_DIV   = 3'(CLK_HZ / TB_HZ);
  localparam logic [23:0] DIV_MIN_S = 24'(TB_HZ / MAX_RATE_S_HZ);
  localparam logic [23:0] DIV_MIN_L = 24'(TB_HZ / MAX_RATE_L_HZ);
  localparam logic [23:0] DIV_MAX  = 24'(TB_HZ * 1000 / MIN_RATE_MHZ);

endpackage

// ---- rtl/aopt_fifo_mem.sv ----
`timescale 1ns/1ps
module aopt_fifo_mem
  import aopt_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                wr_en,
  input  wire logic [FIFO_AW-1:0]  wr_addr,
  input  wire logic [CODE_W-1:0]   wr_data,
  input  wire logic [FIFO_AW-1:0]  rd_addr,
  output logic      [CODE_W-1:0]   rd_data_r
);

  logic [CODE_W-1:0] mem [FIFO_DEPTH];

  // ------------------------------------------------------------
  // Storage, registered read
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= mem[rd_addr];
  end

endmodule // aopt_fifo_mem

// ---- rtl/aopt_top.sv ----
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// How it works
// RULE1: Output codes are 12 bits on small variant, 16 on large; fixed.
// RULE2: Each channel stages its sample, then copies it whole to the output.
// RULE3: Reset leaves held output codes alone; power-up sets midscale.
// RULE4: Channel list holds one or two entries, starting at either channel.
// RULE5: A pacing event updates all listed channels in the same cycle.
// RULE6: Large variant has per-channel filter enables, cleared at reset.
// RULE7: Software picks pacing from 24-bit divider or external clock pin.
// RULE8: Divider counts 20 MHz ticks; active-low pulse, falling edge paces.
// RULE9: Internal rate spans 1.2 Hz to 500 kHz or 200 kHz by variant.
// RULE10: External pacing starts one conversion per falling clock edge.
// RULE11: Software start write is the trigger event under software trigger.
// RULE12: External trigger pin edge polarity is chosen by software.
// RULE13: Threshold trigger fires on upward or downward crossing, by setting.
// RULE14: Threshold source is external analog input or an input channel.
// RULE15: Software puts the trigger input channel first in its input list.
// RULE16: Threshold is an 8-bit code software writes; hysteresis is analog.
// RULE17: Software uses one threshold source type for input and output.
// RULE18: In FIFO mode even samples go to entry 0, odd to entry 1.
// RULE19: FIFO count rises on load, falls on read, zero on FIFO reset.
// RULE20: Pacing edges are ignored until the trigger, then each updates.
module aopt_top
  import aopt_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ext_pace_clk,
  input  wire logic        ext_trig,
  input  wire logic        ana_ext_above,
  input  wire logic        ana_ai_above,
  output logic      [15:0] analog_out_ch_zero,
  output logic      [15:0] analog_out_ch_one,
  output logic      [1:0]  ao_filt_en,
  output logic      [7:0]  thresh_code,
  output logic             pace_out_n
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_RD0, S_CAP0, S_CAP1, S_LOAD
  } aopt_state_t;

  localparam logic [15:0] MID_CODE = LARGE_VARIANT ? MID_CODE_16
                                                   : MID_CODE_12;
  localparam logic [15:0] CODE_MASK = LARGE_VARIANT ? 16'hffff : MASK_12;
  localparam logic [23:0] DIV_MIN = LARGE_VARIANT ? DIV_MIN_L : DIV_MIN_S;

  aopt_ctrl_t          ctrl_r;
  aopt_state_t         st_r;
  logic [23:0]         div_r;
  logic [23:0]         div_eff;
  logic [15:0]         stage_r [2];
  logic [15:0]         ao_zero_r = MID_CODE;
  logic [15:0]         ao_one_r  = MID_CODE;
  logic [7:0]          thresh_r;
  logic [1:0]          filt_r;
  logic                ack_r;
  logic                wait_r;
  logic [31:0]         rdata_r;
  logic [31:0]         rd_mux;
  logic                wr_go;
  logic                cmd_start;
  logic                cmd_stop;
  logic                cmd_frst;
  logic [3:0]          sy1_r;
  logic [3:0]          sy2_r;
  logic [3:0]          sy3_r;
  logic [3:0]          lvl_r;
  logic [3:0]          lvl_d_r;
  logic                armed_r;
  logic                trig_r;
  logic                trig_evt;
  logic                ana_lvl;
  logic                ana_lvl_d;
  logic [2:0]          tb_cnt_r;
  logic [23:0]         pcnt_r;
  logic                pace_n_r;
  logic                pace_n_d_r;
  logic                pace_evt;
  logic [FIFO_AW-1:0]  wptr_r;
  logic [FIFO_AW-1:0]  rptr_r;
  logic [12:0]         fcnt_r;
  logic                push;
  logic                pop;
  logic [15:0]         mem_q;
  logic                need_two;

  // ------------------------------------------------------------
  // Avalon slave: one wait cycle, then a one-cycle answer
  // ------------------------------------------------------------
  assign wr_go     = avs_write && ack_r;
  assign cmd_start = wr_go && avs_address == OFS_CMD
                     && avs_writedata[CMD_START_BIT];
  assign cmd_stop  = wr_go && avs_address == OFS_CMD
                     && avs_writedata[CMD_STOP_BIT];
  assign cmd_frst  = wr_go && avs_address == OFS_CMD
                     && avs_writedata[CMD_FRST_BIT];

  // Read mux; unmapped and write-only words read zero
  always_comb begin
    rd_mux = '0;
    case (avs_address)
      OFS_CTRL:   rd_mux = 32'(ctrl_r);
      OFS_DIV:    rd_mux = 32'(div_r);
      OFS_DATA0:  rd_mux = 32'(stage_r[0]);
      OFS_DATA1:  rd_mux = 32'(stage_r[1]);
      OFS_THRESH: rd_mux = 32'(thresh_r);
      OFS_STAT: begin
        rd_mux[STAT_ARM_BIT] = armed_r;
        rd_mux[STAT_TRG_BIT] = trig_r;
        rd_mux[STAT_CNT_LSB +: 13] = fcnt_r;
      end
      default:    rd_mux = '0;
    endcase
  end

  // Handshake; ack drops after the taken edge so requests never merge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r   <= 1'b0;
      wait_r  <= 1'b1;
      rdata_r <= '0;
    end else begin
      ack_r  <= (avs_read || avs_write) && !ack_r;
      // Own flop so the pin carries no inverter delay
      wait_r <= !((avs_read || avs_write) && !ack_r);
      if (avs_read && !ack_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r   <= CTRL_RST;
      div_r    <= DIV_RST;
      thresh_r <= THRESH_RST;
    end else if (wr_go) begin
      case (avs_address)
        OFS_CTRL:   ctrl_r   <= aopt_ctrl_t'(avs_writedata[9:0]);
        OFS_DIV:    div_r    <= avs_writedata[23:0];
        OFS_THRESH: thresh_r <= avs_writedata[7:0]; // RULE16
        default:    ;
      endcase
    end
  end

  // Filters exist on the large variant only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      filt_r <= 2'h0; // RULE6
    end else begin
      filt_r <= LARGE_VARIANT ? ctrl_r.filt_en : 2'h0; // RULE6
    end
  end

  assign ao_filt_en  = filt_r;
  assign thresh_code = thresh_r; // RULE16

  // ------------------------------------------------------------
  // Pin synchronisers: pace clock, trigger, two comparators
  // ------------------------------------------------------------
  // Level moves only when stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1_r   <= 4'hf;
      sy2_r   <= 4'hf;
      sy3_r   <= 4'hf;
      lvl_r   <= 4'hf;
      lvl_d_r <= 4'hf;
    end else begin
      sy1_r   <= {ana_ai_above, ana_ext_above, ext_trig, ext_pace_clk};
      sy2_r   <= sy1_r;
      sy3_r   <= sy2_r;
      lvl_r   <= (sy2_r & sy3_r) | (lvl_r & (sy2_r ^ sy3_r));
      lvl_d_r <= lvl_r;
    end
  end

  // ------------------------------------------------------------
  // Trigger selection
  // ------------------------------------------------------------
  assign ana_lvl   = ctrl_r.ana_ai ? lvl_r[3] : lvl_r[2]; // RULE14
  assign ana_lvl_d = ctrl_r.ana_ai ? lvl_d_r[3] : lvl_d_r[2];

  always_comb begin
    case (ctrl_r.trig_src)
      TRIG_SW:  trig_evt = cmd_start; // RULE11
      TRIG_EXT: trig_evt = ctrl_r.trig_rise ? (lvl_r[1] && !lvl_d_r[1])
                                            : (!lvl_r[1] && lvl_d_r[1]); // RULE12
      TRIG_ANA: trig_evt = ctrl_r.trig_rise ? (ana_lvl && !ana_lvl_d)
                                            : (!ana_lvl && ana_lvl_d); // RULE13
      default:  trig_evt = 1'b0;
    endcase
  end

  // Start arms; stop wins and disarms
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_r <= 1'b0;
      trig_r  <= 1'b0;
    end else if (cmd_stop) begin
      armed_r <= 1'b0;
      trig_r  <= 1'b0;
    end else begin
      if (cmd_start) begin
        armed_r <= 1'b1;
      end
      if ((armed_r || cmd_start) && trig_evt) begin
        trig_r <= 1'b1; // RULE11 RULE20
      end
    end
  end

  // ------------------------------------------------------------
  // Internal pacing divider on the 20 MHz time base
  // ------------------------------------------------------------
  // Out-of-range divisors are clamped rather than refused
  assign div_eff = (div_r < DIV_MIN) ? DIV_MIN :
                   (div_r > DIV_MAX) ? DIV_MAX : div_r; // RULE9

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tb_cnt_r <= 3'h0;
      pcnt_r   <= 24'h0;
      pace_n_r <= 1'b1;
    end else if (!trig_r) begin
      tb_cnt_r <= 3'h0;
      pcnt_r   <= div_eff - 24'h1;
      pace_n_r <= 1'b1;
    end else if (tb_cnt_r == TB_DIV - 3'h1) begin
      tb_cnt_r <= 3'h0; // RULE8
      if (pcnt_r == 24'h0) begin
        pcnt_r   <= div_eff - 24'h1;
        pace_n_r <= 1'b0; // RULE8
      end else begin
        pcnt_r   <= pcnt_r - 24'h1;
        pace_n_r <= 1'b1;
      end
    end else begin
      tb_cnt_r <= tb_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pace_n_d_r <= 1'b1;
    end else begin
      pace_n_d_r <= pace_n_r;
    end
  end

  assign pace_out_n = pace_n_r;

  // Falling edge of the chosen source paces one update
  assign pace_evt = trig_r && (ctrl_r.clk_ext
                    ? (!lvl_r[0] && lvl_d_r[0]) // RULE10
                    : (!pace_n_r && pace_n_d_r)); // RULE7 RULE8

  // ------------------------------------------------------------
  // Output FIFO and occupancy counter
  // ------------------------------------------------------------
  assign push = wr_go && avs_address == OFS_FIFO
                && fcnt_r != 13'(FIFO_DEPTH);
  assign pop  = (st_r == S_RD0) || (st_r == S_CAP0 && need_two);
  assign need_two = ctrl_r.two_entries;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_r <= '0;
      rptr_r <= '0;
      fcnt_r <= '0;
    end else if (cmd_frst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      fcnt_r <= '0; // RULE19
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 12'h1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 12'h1;
      end
      fcnt_r <= fcnt_r + 13'(push) - 13'(pop); // RULE19
    end
  end

  aopt_fifo_mem u_mem (
    .ref_clk   (ref_clk),
    .wr_en     (push),
    .wr_addr   (wptr_r),
    .wr_data   (avs_writedata[15:0] & CODE_MASK),
    .rd_addr   (rptr_r),
    .rd_data_r (mem_q)
  );

  // ------------------------------------------------------------
  // Update sequencer
  // ------------------------------------------------------------
  // Too few samples means the last codes are simply held
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= S_IDLE;
    end else begin
      case (st_r)
        S_IDLE: begin
          if (pace_evt && !ctrl_r.fifo_mode) begin
            st_r <= S_LOAD; // RULE20
          end else if (pace_evt
                       && fcnt_r >= (need_two ? 13'h2 : 13'h1)) begin
            st_r <= S_RD0;
          end
        end
        S_RD0:   st_r <= S_CAP0;
        S_CAP0:  st_r <= need_two ? S_CAP1 : S_LOAD;
        S_CAP1:  st_r <= S_LOAD;
        S_LOAD:  st_r <= S_IDLE;
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Staging: host writes, or FIFO samples even/odd to entry 0/1
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_r[0] <= MID_CODE;
      stage_r[1] <= MID_CODE;
    end else if (st_r == S_CAP0) begin
      stage_r[ctrl_r.first_one] <= mem_q; // RULE18 RULE4
    end else if (st_r == S_CAP1) begin
      stage_r[!ctrl_r.first_one] <= mem_q; // RULE18
    end else if (wr_go && avs_address == OFS_DATA0) begin
      stage_r[0] <= avs_writedata[15:0] & CODE_MASK; // RULE1 RULE2
    end else if (wr_go && avs_address == OFS_DATA1) begin
      stage_r[1] <= avs_writedata[15:0] & CODE_MASK; // RULE1 RULE2
    end
  end

  // Held codes have no reset so a board reset keeps them
  always_ff @(posedge ref_clk) begin
    if (st_r == S_LOAD) begin
      if (need_two || !ctrl_r.first_one) begin
        ao_zero_r <= stage_r[0]; // RULE2 RULE3 RULE4 RULE5
      end
      if (need_two || ctrl_r.first_one) begin
        ao_one_r  <= stage_r[1]; // RULE2 RULE3 RULE4 RULE5
      end
    end
  end

  assign analog_out_ch_zero = ao_zero_r;
  assign analog_out_ch_one  = ao_one_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_bus_ack_pulse: assert property ( // Avalon handshake, this design's own choice
    @(posedge ref_clk) disable iff (!rst_b)
    (avs_read || avs_write) && !avs_waitrequest |=> avs_waitrequest)
    else $error("answer lasted more than one cycle");

  chk_width_fixed: assert property ( // RULE1
    @(posedge ref_clk) disable iff (!rst_b)
    !LARGE_VARIANT |-> (analog_out_ch_zero[15:12] == 4'h0
                        && analog_out_ch_one[15:12] == 4'h0))
    else $error("code wider than small variant allows");

  chk_codes_cause: assert property ( // RULE2
    @(posedge ref_clk) disable iff (!rst_b)
    (ao_zero_r != $past(ao_zero_r)) |-> $past(st_r) == S_LOAD)
    else $error("output code moved without a load");

  chk_load_together: assert property ( // RULE5
    @(posedge ref_clk) disable iff (!rst_b)
    (st_r == S_LOAD && need_two) |=>
      (ao_zero_r == $past(stage_r[0]) && ao_one_r == $past(stage_r[1])))
    else $error("listed channels not updated together");

  chk_filter_gate: assert property ( // RULE6
    @(posedge ref_clk) disable iff (!rst_b)
    ##1 ao_filt_en == (LARGE_VARIANT ? $past(ctrl_r.filt_en) : 2'h0))
    else $error("filter enable not following control");

  // A stop may legally cut a pulse short, so it ends the check
  chk_pace_pulse: assert property ( // RULE8
    @(posedge ref_clk) disable iff (!rst_b || !trig_r)
    $fell(pace_out_n) && trig_r |-> !pace_out_n [*5])
    else $error("pacing pulse not one time-base period low");

  chk_div_range: assert property ( // RULE9
    @(posedge ref_clk) disable iff (!rst_b)
    div_eff >= DIV_MIN && div_eff <= DIV_MAX)
    else $error("pacing divisor outside the legal range");

  chk_idle_untrig: assert property ( // RULE20
    @(posedge ref_clk) disable iff (!rst_b)
    !trig_r && st_r == S_IDLE |=> st_r == S_IDLE)
    else $error("update started before the trigger");

  chk_sw_start: assert property ( // RULE11
    @(posedge ref_clk) disable iff (!rst_b)
    cmd_start && !cmd_stop && ctrl_r.trig_src == TRIG_SW |=> trig_r)
    else $error("software start did not trigger");

  chk_fifo_count: assert property ( // RULE19
    @(posedge ref_clk) disable iff (!rst_b)
    push && !pop && !cmd_frst |=> fcnt_r == $past(fcnt_r) + 13'h1)
    else $error("FIFO count missed a load");

endmodule // aopt_top

// ---- verif/aopt_host.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Host model: Avalon-MM master
// ----------------------------------------
module aopt_host (
  input  wire logic        ref_clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic      [4:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata
);
  // Idle bus from time zero
  initial begin
    avs_address   = '0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = '0;
  end

  // One access; no wait count assumed, the bench watchdog cuts hangs
  task automatic xfer(input logic rnw, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_read      <= rnw;
    avs_write     <= !rnw;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
  endtask

  // Write one word
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b0, a, d, q);
  endtask

  // Read one word
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    xfer(1'b1, a, '0, q);
  endtask
endmodule // aopt_host

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb
  import aopt_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_b;
  logic        ext_pace_clk;
  logic        ext_trig;
  logic        ana_ext_above;
  logic        ana_ai_above;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] ch0;
  logic [15:0] ch1;
  logic [1:0]  filt;
  logic [7:0]  thr;
  logic        pace_n;
  int          errors = 0;
  int          total_checks = 0;
  time         t0;
  time         t1;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  // Last change time per channel, to prove simultaneous updates
  always @(ch0) t0 = $time;
  always @(ch1) t1 = $time;

  aopt_host u_host (
    .ref_clk        (ref_clk),
    .avs_readdata   (avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .avs_address    (avs_address),
    .avs_read       (avs_read),
    .avs_write      (avs_write),
    .avs_writedata  (avs_writedata)
  );

  aopt_top u_dut (
    .ref_clk           (ref_clk),
    .rst_b             (rst_b),
    .avs_address       (avs_address),
    .avs_read          (avs_read),
    .avs_write         (avs_write),
    .avs_writedata     (avs_writedata),
    .avs_readdata      (avs_readdata),
    .avs_waitrequest   (avs_waitrequest),
    .ext_pace_clk      (ext_pace_clk),
    .ext_trig          (ext_trig),
    .ana_ext_above     (ana_ext_above),
    .ana_ai_above      (ana_ai_above),
    .analog_out_ch_zero(ch0),
    .analog_out_ch_one (ch1),
    .ao_filt_en        (filt),
    .thresh_code       (thr),
    .pace_out_n        (pace_n)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", what, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One external pacing pulse; pins pass a 3-flop synchroniser
  task automatic pace();
    @(posedge ref_clk);
    ext_pace_clk <= 1'b1;
    cyc(8);
    ext_pace_clk <= 1'b0;
    cyc(12);
  endtask

  task automatic wait_low();
    for (int i = 0; i < 3000 && pace_n !== 1'b0; i++) cyc(1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_vals();
    logic [31:0] q;
    chk("ch0 pwrup", 32'h8000, 32'(ch0));
    chk("ch1 pwrup", 32'h8000, 32'(ch1));
    chk("filt rst", 32'h0, 32'(filt));
    chk("thr rst", 32'h80, 32'(thr));
    chk("pace idle", 32'h1, 32'(pace_n));
    u_host.rd(OFS_CTRL, q);
    chk("ctrl rst", 32'h0, q);
    u_host.rd(OFS_DIV, q);
    chk("div rst", 32'(DIV_RST), q);
    u_host.rd(OFS_CMD, q);
    chk("cmd rd", 32'h0, q);
    u_host.rd(5'h1e, q);
    chk("unmapped", 32'h0, q);
  endtask

  task automatic t_internal();
    int lo;
    int per;
    u_host.wr(OFS_DATA0, 32'h1234);
    u_host.wr(OFS_DATA1, 32'habcd);
    u_host.wr(OFS_DIV, 32'd100);
    u_host.wr(OFS_CTRL, 32'h20);
    cyc(20);
    chk("staged only", 32'h8000, 32'(ch0));
    u_host.wr(OFS_CMD, 32'h1);
    wait_low();
    lo = 0;
    while (pace_n === 1'b0 && lo < 50) begin
      cyc(1);
      lo++;
    end
    per = lo;
    while (pace_n === 1'b1 && per < 3000) begin
      cyc(1);
      per++;
    end
    chk("pulse low", 32'd5, 32'(lo));
    chk("period", 32'd500, 32'(per));
    chk("ch0 upd", 32'h1234, 32'(ch0));
    chk("ch1 upd", 32'habcd, 32'(ch1));
    chk("same instant", 32'(t0), 32'(t1));
    u_host.wr(OFS_CMD, 32'h2);
  endtask

  task automatic t_reset_hold();
    logic [31:0] q;
    u_host.wr(OFS_CTRL, 32'h300);
    cyc(2);
    chk("filt on", 32'h3, 32'(filt));
    rst_b <= 1'b0;
    cyc(2);
    chk("ch0 kept", 32'h1234, 32'(ch0));
    chk("ch1 kept", 32'habcd, 32'(ch1));
    chk("filt clr", 32'h0, 32'(filt));
    rst_b <= 1'b1;
    u_host.rd(OFS_CTRL, q);
    chk("ctrl clr", 32'h0, q);
  endtask

  task automatic t_ext();
    u_host.wr(OFS_DATA1, 32'h5555);
    u_host.wr(OFS_CTRL, 32'h4b);
    u_host.wr(OFS_CMD, 32'h1);
    pace();
    chk("untrig", 32'habcd, 32'(ch1));
    ext_trig <= 1'b1;
    cyc(8);
    pace();
    chk("ext ch1", 32'h5555, 32'(ch1));
    chk("ext ch0", 32'h1234, 32'(ch0));
    u_host.wr(OFS_CMD, 32'h2);
    // Falling trigger edge, two entries starting at channel one
    u_host.wr(OFS_DATA0, 32'h2468);
    u_host.wr(OFS_DATA1, 32'h6666);
    u_host.wr(OFS_CTRL, 32'h63);
    u_host.wr(OFS_CMD, 32'h1);
    ext_trig <= 1'b0;
    cyc(8);
    pace();
    chk("fall ch0", 32'h2468, 32'(ch0));
    chk("fall ch1", 32'h6666, 32'(ch1));
    u_host.wr(OFS_CMD, 32'h2);
  endtask

  task automatic t_ana();
    u_host.wr(OFS_DATA0, 32'h0f0f);
    u_host.wr(OFS_DATA1, 32'hf0f0);
    // One source type, the input channel listed first on the input side
    u_host.wr(OFS_CTRL, 32'h35);
    u_host.wr(OFS_CMD, 32'h1);
    ana_ext_above <= 1'b0;
    cyc(8);
    pace();
    chk("wrong src", 32'h2468, 32'(ch0));
    ana_ai_above <= 1'b0;
    cyc(8);
    pace();
    chk("ana ch0", 32'h0f0f, 32'(ch0));
    chk("ana ch1", 32'hf0f0, 32'(ch1));
    u_host.wr(OFS_CMD, 32'h2);
  endtask

  task automatic t_fifo();
    logic [31:0] q;
    u_host.wr(OFS_CMD, 32'h4);
    for (int i = 1; i <= 4; i++) u_host.wr(OFS_FIFO, 32'h1111 * i);
    u_host.rd(OFS_STAT, q);
    chk("count 4", 32'd4, 32'(q[28:16]));
    u_host.wr(OFS_DIV, 32'd100);
    u_host.wr(OFS_CTRL, 32'ha0);
    u_host.wr(OFS_CMD, 32'h1);
    wait_low();
    cyc(10);
    chk("even smp", 32'h1111, 32'(ch0));
    chk("odd smp", 32'h2222, 32'(ch1));
    u_host.rd(OFS_STAT, q);
    chk("count 2", 32'd2, 32'(q[28:16]));
    u_host.wr(OFS_CMD, 32'h6);
    u_host.rd(OFS_STAT, q);
    chk("count 0", 32'd0, 32'(q[28:16]));
  endtask

  task automatic t_thresh();
    logic [31:0] q;
    u_host.wr(OFS_THRESH, 32'h3c);
    cyc(2);
    chk("thr pin", 32'h3c, 32'(thr));
    u_host.rd(OFS_THRESH, q);
    chk("thr reg", 32'h3c, q);
  endtask

  // ----------------------------------------
  // Verdict and run control
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog: run needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    rst_b         = 1'b0;
    ext_pace_clk  = 1'b0;
    ext_trig      = 1'b0;
    ana_ext_above = 1'b1;
    ana_ai_above  = 1'b1;
    cyc(2);
    rst_b <= 1'b1;
    t_reset_vals();
    t_internal();
    t_reset_hold();
    t_ext();
    t_ana();
    t_fifo();
    t_thresh();
    give_verdict();
  end
endmodule // tb
